// ==== fsp_consts.svh ====
// Constants for the flash sector write-protection block
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// Command opcodes
`define FSP_OPC_SET_LATCH 8'h06
`define FSP_OPC_CLR_LATCH 8'h04
`define FSP_OPC_REG_WRITE 8'h01
`define FSP_OPC_PAGE_PROG 8'h02
`define FSP_OPC_QUAD_PROG 8'h32
`define FSP_OPC_SECT_ERASE 8'hd8
`define FSP_OPC_BULK_ERASE 8'hc7
`define FSP_OPC_OTP_PROG 8'h42
`define FSP_OPC_SW_RESET 8'hf0
`define FSP_OPC_DYN_WRITE 8'he1
`define FSP_OPC_PERS_PROG 8'he3
`define FSP_OPC_PERS_ERASE 8'he4
`define FSP_OPC_LOCK_CLR 8'ha6
`define FSP_OPC_UNLOCK 8'he9
`define FSP_OPC_MODE_PROG 8'h2f
`define FSP_OPC_PW_PROG 8'he8

// Frame lengths in bits, opcode included
`define FSP_BITS_OP 7'h08
`define FSP_BITS_1B 7'h10
`define FSP_BITS_2B 7'h18
`define FSP_BITS_PW 7'h48
`define FSP_BITS_MAX 7'h7f

// Register-write payload fields
`define FSP_SR_WDIS 7
`define FSP_SR_BP_LSB 2
`define FSP_CR_TB 5
`define FSP_CR_FREEZE 0
`define FSP_MODE_LSB 1

// Protection modes
`define FSP_MODE_DEFAULT 2'h3
`define FSP_MODE_PERSIST 2'h2
`define FSP_MODE_PASSWORD 2'h1
`define FSP_MODE_ILLEGAL 2'h0

// Synchroniser bit positions
`define FSP_PIN_SCLK 0
`define FSP_PIN_CS_N 1
`define FSP_PIN_MOSI 2
`define FSP_PIN_WP_N 3
`define FSP_PIN_HWRST_N 4

// APB byte addresses
`define FSP_ADDR_STATUS 8'h00
`define FSP_ADDR_OPTIME 8'h04
`define FSP_ADDR_ERR 8'h08
`define FSP_ADDR_SEL 8'h0c
`define FSP_ADDR_SECT 8'h10

// Reset values
`define FSP_OPTIME_RST 16'h0010

`endif

// ==== fsp_pkg.sv ====
// Types shared by the flash sector write-protection block
package fsp_pkg;

    typedef enum {
        FSP_CMD_NONE, FSP_CMD_SET_LATCH, FSP_CMD_CLR_LATCH, FSP_CMD_REG_WRITE,
        FSP_CMD_PROG, FSP_CMD_ERASE, FSP_CMD_BULK, FSP_CMD_OTP, FSP_CMD_SW_RESET,
        FSP_CMD_DYN_WRITE, FSP_CMD_PERS_PROG, FSP_CMD_PERS_ERASE, FSP_CMD_LOCK_CLR,
        FSP_CMD_UNLOCK, FSP_CMD_MODE_PROG, FSP_CMD_PW_PROG
    } fsp_cmd_t;

endpackage : fsp_pkg

// ==== fsp_protect.sv ====
// Flash sector write-protection: command decode, latch, range and sector protection
//
// Behaviour
// - Set-latch command sets write latch flag
// - Latch cleared on reset and write completion
// - Range bits protect fraction from array top
// - Top/bottom select one counts from bottom
// - Sector protected if range or sector bits
// - Freeze bit holds range and selector values
// - Freeze stays set until power-on reset
// - Freeze refuses all OTP programming
// - Range change under freeze ignored, no error
// - Pin low and disable bit block registers
// - Either sector bit zero protects sector
// - Persistent bits locked while global lock zero
// - Persistent mode: lock set at reset
// - Persistent mode: lock never set by command
// - Password mode: lock cleared at reset
// - Password match sets lock; command clears
// - Mode bits 11/10/01 decoded, 00 fails
// - Mode register frozen once mode selected
// - Mode programming shows write-in-progress flag
// - Delivered: default mode, all unprotected
// - Dynamic bit written freely either way
// - Persistent bits programmed singly, erased together
`timescale 1ns/1ps
`include "fsp_consts.svh"

module fsp_protect #(
    // Power of two, 64 to 256, so every range fraction is whole sectors
    parameter int NSEC = 64
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_spi_sclk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_mosi,
    input wire logic i_wp_n,
    input wire logic i_hw_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_prog_pulse,
    output logic o_erase_pulse,
    output logic o_bulk_pulse,
    output logic o_otp_pulse,
    output logic [7:0] o_sector,
    output logic o_busy
);

    localparam int SW = $clog2(NSEC);
    localparam logic [8:0] NSEC9 = 9'(NSEC);

    typedef struct packed {
        logic [4:0] sy1;
        logic [4:0] sy2;
        logic [4:0] sy3;
        logic [4:0] flt;
        logic [6:0] nbits;
        logic [7:0] op;
        logic [63:0] sh;
        logic write_latch_flag;
        logic [2:0] range_bits;
        logic top_bottom_select;
        logic freeze;
        logic status_write_disable_bit;
        logic [1:0] mode;
        logic global_persistent_lock;
        logic [NSEC-1:0] persistent_sector_bit;
        logic [NSEC-1:0] dynamic_sector_bit;
        logic [63:0] password;
        logic err;
        logic write_in_progress_flag;
        logic [15:0] wcnt;
        logic [15:0] op_time;
        logic [7:0] sel;
        logic [31:0] prdata;
        logic pslverr;
        logic prog;
        logic erase;
        logic bulk;
        logic otp;
        logic [7:0] sector;
    } fsp_state_t;

    // Power-on values: the part as delivered
    localparam fsp_state_t RST_VAL = '{
        sy1: '1, sy2: '1, sy3: '1, flt: '1,
        mode: `FSP_MODE_DEFAULT,
        global_persistent_lock: 1'b1,
        persistent_sector_bit: '1,
        dynamic_sector_bit: '1,
        password: '1,
        op_time: `FSP_OPTIME_RST,
        default: '0
    };

    fsp_state_t r;
    fsp_state_t nx;

    function automatic logic in_range(input logic [7:0] s, input logic [2:0] bp,
                                      input logic tb);
        logic [8:0] sz;
        sz = 9'h0;
        if (bp == 3'h7)
        begin
            sz = NSEC9;
        end
        else if (bp != 3'h0)
        begin
            sz = NSEC9 >> (3'h7 - bp);
        end
        if (tb)
        begin
            in_range = {1'b0, s} < sz;
        end
        else
        begin
            in_range = {1'b0, s} >= (NSEC9 - sz);
        end
    endfunction : in_range

    function automatic fsp_pkg::fsp_cmd_t decode(input logic [7:0] op);
        case (op)
            `FSP_OPC_SET_LATCH: decode = fsp_pkg::FSP_CMD_SET_LATCH;
            `FSP_OPC_CLR_LATCH: decode = fsp_pkg::FSP_CMD_CLR_LATCH;
            `FSP_OPC_REG_WRITE: decode = fsp_pkg::FSP_CMD_REG_WRITE;
            `FSP_OPC_PAGE_PROG: decode = fsp_pkg::FSP_CMD_PROG;
            `FSP_OPC_QUAD_PROG: decode = fsp_pkg::FSP_CMD_PROG;
            `FSP_OPC_SECT_ERASE: decode = fsp_pkg::FSP_CMD_ERASE;
            `FSP_OPC_BULK_ERASE: decode = fsp_pkg::FSP_CMD_BULK;
            `FSP_OPC_OTP_PROG: decode = fsp_pkg::FSP_CMD_OTP;
            `FSP_OPC_SW_RESET: decode = fsp_pkg::FSP_CMD_SW_RESET;
            `FSP_OPC_DYN_WRITE: decode = fsp_pkg::FSP_CMD_DYN_WRITE;
            `FSP_OPC_PERS_PROG: decode = fsp_pkg::FSP_CMD_PERS_PROG;
            `FSP_OPC_PERS_ERASE: decode = fsp_pkg::FSP_CMD_PERS_ERASE;
            `FSP_OPC_LOCK_CLR: decode = fsp_pkg::FSP_CMD_LOCK_CLR;
            `FSP_OPC_UNLOCK: decode = fsp_pkg::FSP_CMD_UNLOCK;
            `FSP_OPC_MODE_PROG: decode = fsp_pkg::FSP_CMD_MODE_PROG;
            `FSP_OPC_PW_PROG: decode = fsp_pkg::FSP_CMD_PW_PROG;
            default: decode = fsp_pkg::FSP_CMD_NONE;
        endcase
    endfunction : decode

    logic [NSEC-1:0] rng_vec;
    logic [NSEC-1:0] prot_vec;
    logic [4:0] flt_next;
    logic sclk_rise;
    logic cs_rise;
    logic hw_rst;
    logic [7:0] sarg;
    logic [SW-1:0] sidx;
    logic [SW-1:0] selx;
    logic sec_ok;
    logic sel_ok;
    logic regs_locked;
    logic [31:0] rd;
    logic apb_setup;
    logic apb_access;
    fsp_pkg::fsp_cmd_t cmd;

    genvar g;
    for (g = 0; g < NSEC; g++)
    begin : g_rng
        assign rng_vec[g] = in_range(8'(g), r.range_bits, r.top_bottom_select);
    end

    // Either scheme protects; either sector bit at zero protects
    assign prot_vec = rng_vec | ~r.persistent_sector_bit | ~r.dynamic_sector_bit;

    // A pin change is taken once the second and third stages agree
    assign flt_next = ((r.sy2 ~^ r.sy3) & r.sy3) | ((r.sy2 ^ r.sy3) & r.flt);
    assign sclk_rise = flt_next[`FSP_PIN_SCLK] & ~r.flt[`FSP_PIN_SCLK];
    assign cs_rise = flt_next[`FSP_PIN_CS_N] & ~r.flt[`FSP_PIN_CS_N];
    assign hw_rst = ~r.flt[`FSP_PIN_HWRST_N];
    assign regs_locked = ~r.flt[`FSP_PIN_WP_N] & r.status_write_disable_bit;

    assign sarg = (r.nbits == `FSP_BITS_2B) ? r.sh[15:8] : r.sh[7:0];
    assign sidx = sarg[SW-1:0];
    assign sec_ok = {1'b0, sarg} < NSEC9;
    assign selx = r.sel[SW-1:0];
    assign sel_ok = {1'b0, r.sel} < NSEC9;
    assign cmd = decode(r.op);

    assign apb_setup = i_psel & ~i_penable;
    assign apb_access = i_psel & i_penable;

    always_comb
    begin
        rd = 32'h0;
        case (i_paddr)
            `FSP_ADDR_STATUS: rd = {20'h0, r.mode, r.global_persistent_lock, r.freeze,
                                    r.top_bottom_select, r.status_write_disable_bit,
                                    r.range_bits, r.err, r.write_latch_flag,
                                    r.write_in_progress_flag};
            `FSP_ADDR_OPTIME: rd = {16'h0, r.op_time};
            `FSP_ADDR_ERR: rd = {31'h0, r.err};
            `FSP_ADDR_SEL: rd = {24'h0, r.sel};
            `FSP_ADDR_SECT:
            begin
                if (sel_ok)
                begin
                    rd = {28'h0, prot_vec[selx], rng_vec[selx],
                          r.dynamic_sector_bit[selx], r.persistent_sector_bit[selx]};
                end
            end
            default: rd = 32'h0;
        endcase
    end

    always_comb
    begin
        nx = r;
        nx.prog = 1'b0;
        nx.erase = 1'b0;
        nx.bulk = 1'b0;
        nx.otp = 1'b0;
        nx.sy1 = {i_hw_reset_n, i_wp_n, i_spi_mosi, i_spi_cs_n, i_spi_sclk};
        nx.sy2 = r.sy1;
        nx.sy3 = r.sy2;
        nx.flt = flt_next;

        // Read data is captured in the setup cycle
        if (apb_setup)
        begin
            nx.prdata = rd;
            nx.pslverr = !(i_paddr inside {`FSP_ADDR_STATUS, `FSP_ADDR_OPTIME,
                                           `FSP_ADDR_ERR, `FSP_ADDR_SEL, `FSP_ADDR_SECT});
        end
        if (apb_access && i_pwrite && !r.pslverr)
        begin
            case (i_paddr)
                `FSP_ADDR_OPTIME: nx.op_time = i_pwdata[15:0];
                `FSP_ADDR_ERR: nx.err = r.err & ~i_pwdata[0];
                `FSP_ADDR_SEL: nx.sel = i_pwdata[7:0];
                default: nx.sel = r.sel;
            endcase
        end

        // Busy period of a write; the latch drops when it ends
        if (r.write_in_progress_flag)
        begin
            nx.wcnt = r.wcnt - 16'h1;
            if (r.wcnt <= 16'h1)
            begin
                nx.write_in_progress_flag = 1'b0;
                nx.write_latch_flag = 1'b0;
            end
        end

        // Frame shift-in, most significant bit first
        if (r.flt[`FSP_PIN_CS_N])
        begin
            nx.nbits = 7'h0;
        end
        else if (sclk_rise)
        begin
            if (r.nbits < `FSP_BITS_OP)
            begin
                nx.op = {r.op[6:0], r.flt[`FSP_PIN_MOSI]};
            end
            else
            begin
                nx.sh = {r.sh[62:0], r.flt[`FSP_PIN_MOSI]};
            end
            if (r.nbits != `FSP_BITS_MAX)
            begin
                nx.nbits = r.nbits + 7'h1;
            end
        end

        // Commands execute when chip select rises; frames while busy are dropped
        if (cs_rise && !r.write_in_progress_flag && !hw_rst)
        begin
            nx.op = 8'h0;
            case (cmd)
                fsp_pkg::FSP_CMD_SET_LATCH:
                begin
                    if (r.nbits == `FSP_BITS_OP)
                    begin
                        nx.write_latch_flag = 1'b1;
                    end
                end
                fsp_pkg::FSP_CMD_CLR_LATCH: nx.write_latch_flag = 1'b0;
                fsp_pkg::FSP_CMD_SW_RESET:
                begin
                    nx.write_latch_flag = 1'b0;
                    nx.dynamic_sector_bit = '1;
                end
                fsp_pkg::FSP_CMD_REG_WRITE:
                begin
                    if (r.write_latch_flag && r.nbits == `FSP_BITS_2B)
                    begin
                        nx.write_in_progress_flag = 1'b1;
                        nx.wcnt = r.op_time;
                        // Blocked silently while the pin guards the registers
                        if (!regs_locked)
                        begin
                            nx.status_write_disable_bit = r.sh[8 + `FSP_SR_WDIS];
                            // Frozen range bits keep their value without an error
                            if (!r.freeze)
                            begin
                                nx.range_bits = r.sh[8 + `FSP_SR_BP_LSB +: 3];
                                nx.top_bottom_select = r.sh[`FSP_CR_TB];
                            end
                            nx.freeze = r.freeze | r.sh[`FSP_CR_FREEZE];
                        end
                    end
                end
                fsp_pkg::FSP_CMD_PROG, fsp_pkg::FSP_CMD_ERASE:
                begin
                    if (r.write_latch_flag && r.nbits == `FSP_BITS_1B)
                    begin
                        nx.write_in_progress_flag = 1'b1;
                        nx.wcnt = r.op_time;
                        nx.sector = sarg;
                        if (!sec_ok || prot_vec[sidx])
                        begin
                            nx.err = 1'b1;
                        end
                        else
                        begin
                            nx.prog = (cmd == fsp_pkg::FSP_CMD_PROG);
                            nx.erase = (cmd == fsp_pkg::FSP_CMD_ERASE);
                        end
                    end
                end
                fsp_pkg::FSP_CMD_BULK:
                begin
                    if (r.write_latch_flag && r.nbits == `FSP_BITS_OP)
                    begin
                        nx.write_in_progress_flag = 1'b1;
                        nx.wcnt = r.op_time;
                        nx.err = nx.err | (|prot_vec);
                        nx.bulk = ~(|prot_vec);
                    end
                end
                fsp_pkg::FSP_CMD_OTP:
                begin
                    if (r.write_latch_flag)
                    begin
                        nx.write_in_progress_flag = 1'b1;
                        nx.wcnt = r.op_time;
                        nx.err = nx.err | r.freeze;
                        nx.otp = ~r.freeze;
                    end
                end
                fsp_pkg::FSP_CMD_DYN_WRITE:
                begin
                    if (r.nbits == `FSP_BITS_2B && sec_ok)
                    begin
                        nx.dynamic_sector_bit[sidx] = r.sh[0];
                    end
                end
                fsp_pkg::FSP_CMD_PERS_PROG, fsp_pkg::FSP_CMD_PERS_ERASE:
                begin
                    if (r.write_latch_flag)
                    begin
                        nx.write_in_progress_flag = 1'b1;
                        nx.wcnt = r.op_time;
                        if (!r.global_persistent_lock)
                        begin
                            nx.err = 1'b1;
                        end
                        else if (cmd == fsp_pkg::FSP_CMD_PERS_ERASE)
                        begin
                            nx.persistent_sector_bit = '1;
                        end
                        else if (r.nbits == `FSP_BITS_1B && sec_ok)
                        begin
                            nx.persistent_sector_bit[sidx] = 1'b0;
                        end
                    end
                end
                // No command sets the lock in persistent mode
                fsp_pkg::FSP_CMD_LOCK_CLR: nx.global_persistent_lock = 1'b0;
                fsp_pkg::FSP_CMD_UNLOCK:
                begin
                    if (r.mode == `FSP_MODE_PASSWORD && r.nbits == `FSP_BITS_PW)
                    begin
                        if (r.sh == r.password)
                        begin
                            nx.global_persistent_lock = 1'b1;
                        end
                        else
                        begin
                            nx.err = 1'b1;
                        end
                    end
                end
                fsp_pkg::FSP_CMD_MODE_PROG:
                begin
                    if (r.write_latch_flag && r.nbits == `FSP_BITS_1B)
                    begin
                        nx.write_in_progress_flag = 1'b1;
                        nx.wcnt = r.op_time;
                        if (r.mode != `FSP_MODE_DEFAULT)
                        begin
                            nx.err = 1'b1;
                        end
                        else if (r.sh[`FSP_MODE_LSB +: 2] == `FSP_MODE_ILLEGAL)
                        begin
                            nx.err = 1'b1;
                        end
                        else
                        begin
                            nx.mode = r.sh[`FSP_MODE_LSB +: 2];
                        end
                    end
                end
                fsp_pkg::FSP_CMD_PW_PROG:
                begin
                    if (r.write_latch_flag && r.nbits == `FSP_BITS_PW)
                    begin
                        nx.write_in_progress_flag = 1'b1;
                        nx.wcnt = r.op_time;
                        // Only zeros can be programmed, and only before a mode is chosen
                        if (r.mode == `FSP_MODE_DEFAULT)
                        begin
                            nx.password = r.password & r.sh;
                        end
                        else
                        begin
                            nx.err = 1'b1;
                        end
                    end
                end
                default: nx.op = 8'h0;
            endcase
        end

        // Hardware reset pin; freeze survives it, only power-on clears that
        if (hw_rst)
        begin
            nx.write_latch_flag = 1'b0;
            nx.global_persistent_lock = (r.mode != `FSP_MODE_PASSWORD);
            nx.dynamic_sector_bit = '1;
            nx.write_in_progress_flag = 1'b0;
            nx.nbits = 7'h0;
            nx.op = 8'h0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            r <= RST_VAL;
        end
        else
        begin
            r <= nx;
        end
    end

    assign o_prdata = r.prdata;
    assign o_pready = apb_access;
    assign o_pslverr = r.pslverr;
    assign o_prog_pulse = r.prog;
    assign o_erase_pulse = r.erase;
    assign o_bulk_pulse = r.bulk;
    assign o_otp_pulse = r.otp;
    assign o_sector = r.sector;
    assign o_busy = r.write_in_progress_flag;

endmodule : fsp_protect

// ==== fsp_protect_sva.sv ====
// Port checker for the sector write-protection block
`timescale 1ns/1ps
module fsp_protect_sva (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_spi_cs_n,
    input wire logic i_hw_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [7:0] i_paddr,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_prog_pulse,
    input wire logic o_erase_pulse,
    input wire logic o_bulk_pulse,
    input wire logic o_otp_pulse,
    input wire logic o_busy
);
    wire logic [3:0] g = {o_prog_pulse, o_erase_pulse, o_bulk_pulse, o_otp_pulse};
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    property p_rdy; o_pready == (i_psel && i_penable); endproperty
    a_rdy: assert property (p_rdy) else $error("pready not tied to access phase");
    property p_unmap; i_psel && !i_penable && i_paddr > 8'h10 |=> o_pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped address accepted");
    property p_gbusy; g != 4'h0 |-> o_busy ##1 o_busy; endproperty
    a_gbusy: assert property (p_gbusy) else $error("grant without busy");
    property p_nolap; g != 4'h0 |-> !$past(o_busy); endproperty
    a_nolap: assert property (p_nolap) else $error("grant while busy");
    property p_pulse; g != 4'h0 |=> g == 4'h0; endproperty
    a_pulse: assert property (p_pulse) else $error("grant longer than a cycle");
    property p_one; $onehot0(g); endproperty
    a_one: assert property (p_one) else $error("two grants at once");
    // Commands run only once the frame has closed
    property p_frame; g != 4'h0 |-> $past(i_spi_cs_n, 3); endproperty
    a_frame: assert property (p_frame) else $error("grant inside a frame");
    property p_hw; !i_hw_reset_n [*6] |-> !o_busy && g == 4'h0; endproperty
    a_hw: assert property (p_hw) else $error("activity under pin reset");
    c_prog: cover property (o_prog_pulse);
    c_bulk: cover property (o_bulk_pulse);
    c_otp: cover property (o_otp_pulse);
endmodule : fsp_protect_sva
bind fsp_protect fsp_protect_sva u_sva (.*);

// ==== fsp_spi_host.sv ====
// Behavioural SPI host shifting command frames into the block
`timescale 1ns/1ps
module fsp_spi_host (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi
);
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // Left-aligned frame, MSB first; the offset keeps edges off the clock
    task automatic send(input logic [71:0] f, input int n);
        #7 o_cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            o_mosi = f[71-i];
            #100 o_sclk = 1'b1;
            #100 o_sclk = 1'b0;
        end
        // A released line must not keep showing the last bit
        o_mosi = ~o_mosi;
        #100 o_cs_n = 1'b1;
        #300;
    endtask : send
endmodule : fsp_spi_host

// ==== tb_top.sv ====
// Self-checking bench for the sector write-protection block
`timescale 1ns/1ps
module tb_top;
    localparam int NSEC = 64;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic wp_n = 1'b1, hw_n = 1'b1;
    logic [7:0] pa = 8'h00, sec;
    logic [31:0] pwd = 32'h0, prd, q;
    logic rdy, serr, pg, pe, pb, po, busy, sclk, cs_n, mosi, r;
    logic [3:0] gk;
    int err_total = 0, check_count = 0, seed = 91, ng = 0, s, c;
    logic [7:0] ops [5] = '{8'h02, 8'h32, 8'hd8, 8'hc7, 8'h42};
    logic [3:0] kinds [5] = '{4'h8, 4'h8, 4'h4, 4'h2, 4'h1};
    fsp_protect #(.NSEC(NSEC)) dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_spi_sclk(sclk),
        .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .i_wp_n(wp_n), .i_hw_reset_n(hw_n),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
        .o_prdata(prd), .o_pready(rdy), .o_pslverr(serr), .o_prog_pulse(pg),
        .o_erase_pulse(pe), .o_bulk_pulse(pb), .o_otp_pulse(po), .o_sector(sec),
        .o_busy(busy));
    fsp_spi_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        #1000000;
        err_total++;
        end_of_test();
    end
    always @(posedge clk)
    begin
        if ((pg | pe | pb | po) === 1'b1)
        begin
            ng <= ng + 1;
            gk <= {pg, pe, pb, po};
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] v, input logic [31:0] e);
        check_count++;
        if (v !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, v);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1)
            @(posedge clk);
        q = prd;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic rd(input string nm, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, 8'h00, 32'h0);
        chk(nm, q & m, e);
    endtask : rd
    task automatic sect(input int n, input logic [3:0] e);
        apb(1'b1, 8'h0c, n);
        apb(1'b0, 8'h10, 32'h0);
        chk("sector bits", q, {28'h0, e});
    endtask : sect
    // Writing commands carry their own set-latch frame when wl is high
    task automatic cmd(input logic wl, input logic [71:0] f, input int n);
        if (wl)
            host.send({8'h06, 64'h0}, 8);
        host.send(f, n);
        repeat (2) @(posedge clk);
        while (busy !== 1'b0)
            @(posedge clk);
    endtask : cmd
    task automatic hwrst();
        hw_n <= 1'b0;
        repeat (8) @(posedge clk);
        hw_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : hwrst
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd("status", 32'hffffffff, 32'h00000e00);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", {31'h0, serr}, 32'h1);
        apb(1'b1, 8'h04, 32'h4);
        cmd(1'b0, {8'h06, 64'h0}, 8);
        rd("latch", 32'h2, 32'h2);
        cmd(1'b0, {8'h04, 64'h0}, 8);
        rd("latch", 32'h2, 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            s = {$random(seed)} % NSEC;
            c = ng;
            cmd(1'b1, {ops[i], s[7:0], 56'h0}, ops[i] == 8'hc7 ? 8 : 16);
            chk("grant", {24'h0, gk, 4'(ng - c)}, {24'h0, kinds[i], 4'h1});
            if (i < 3)
                chk("sector", {24'h0, sec}, s);
            rd("latch", 32'h3, 32'h0);
        end
        $display("commands done");
        for (int t = 0; t < 2; t++)
            for (int b = 0; b < 8; b++)
            begin
                cmd(1'b1, {8'h01, 3'h0, b[2:0], 4'h0, t[0], 5'h0, 48'h0}, 24);
                c = (b == 0) ? 0 : NSEC >> (7 - b);
                for (int j = 0; j < 5; j++)
                begin
                    s = (j == 0 ? c : j == 1 ? c + NSEC - 1 : j == 2 ? NSEC - c :
                        j == 3 ? 2 * NSEC - c - 1 : {$random(seed)}) % NSEC;
                    r = t ? s < c : s >= NSEC - c;
                    sect(s, {r, r, 2'h3});
                end
            end
        c = ng;
        cmd(1'b1, {8'h02, 8'h00, 56'h0}, 16);
        chk("range refusal", ng, c);
        apb(1'b1, 8'h08, 32'h1);
        cmd(1'b1, {8'h01, 64'h0}, 24);
        $display("range done");
        s = {$random(seed)} % NSEC;
        cmd(1'b0, {8'he1, s[7:0], 8'h00, 48'h0}, 24);
        sect(s, 4'h9);
        c = ng;
        cmd(1'b1, {8'hd8, s[7:0], 56'h0}, 16);
        cmd(1'b1, {8'hc7, 64'h0}, 8);
        chk("sector refusal", ng, c);
        cmd(1'b0, {8'he1, s[7:0], 8'h01, 48'h0}, 24);
        sect(s, 4'h3);
        cmd(1'b1, {8'he3, s[7:0], 56'h0}, 16);
        sect(s, 4'ha);
        cmd(1'b1, {8'he4, 64'h0}, 8);
        sect(s, 4'h3);
        cmd(1'b0, {8'ha6, 64'h0}, 8);
        cmd(1'b0, {8'he9, 64'hffffffffffffffff}, 72);
        rd("lock", 32'h200, 32'h0);
        cmd(1'b1, {8'hf0, 64'h0}, 8);
        rd("sw reset", 32'h2, 32'h0);
        apb(1'b1, 8'h08, 32'h1);
        cmd(1'b1, {8'he3, s[7:0], 56'h0}, 16);
        sect(s, 4'h3);
        rd("error", 32'h4, 32'h4);
        cmd(1'b0, {8'h06, 64'h0}, 8);
        hwrst();
        rd("pin reset", 32'h202, 32'h200);
        $display("sector bits done");
        apb(1'b1, 8'h08, 32'h1);
        cmd(1'b1, {8'h01, 8'h88, 8'h00, 48'h0}, 24);
        wp_n <= 1'b0;
        cmd(1'b1, {8'h01, 8'h0c, 8'h00, 48'h0}, 24);
        rd("pin guard", 32'h78, 32'h50);
        wp_n <= 1'b1;
        cmd(1'b1, {8'h01, 8'h08, 8'h01, 48'h0}, 24);
        cmd(1'b1, {8'h01, 8'h14, 8'h20, 48'h0}, 24);
        rd("freeze", 32'h1bc, 32'h110);
        c = ng;
        cmd(1'b1, {8'h42, 64'h0}, 16);
        chk("otp refusal", ng, c);
        hwrst();
        rd("freeze kept", 32'h100, 32'h100);
        apb(1'b1, 8'h08, 32'h1);
        cmd(1'b1, {8'h2f, 8'h00, 56'h0}, 16);
        rd("mode 00", 32'hc04, 32'hc04);
        cmd(1'b1, {8'he8, 64'h0123456789abcdef}, 72);
        cmd(1'b1, {8'h2f, 8'h02, 56'h0}, 16);
        cmd(1'b1, {8'h2f, 8'h04, 56'h0}, 16);
        rd("mode", 32'hc00, 32'h400);
        hwrst();
        rd("lock", 32'h200, 32'h0);
        cmd(1'b0, {8'he9, 64'h0123456789abcdee}, 72);
        rd("lock", 32'h200, 32'h0);
        cmd(1'b0, {8'he9, 64'h0123456789abcdef}, 72);
        rd("lock", 32'h200, 32'h200);
        cmd(1'b0, {8'ha6, 64'h0}, 8);
        rd("lock", 32'h200, 32'h0);
        $display("modes done");
        end_of_test();
    end
endmodule : tb_top
